// file: rtl/relay_seq_consts.svh
// Constants for the dual-interval relay sequencer
`ifndef RELAY_SEQ_CONSTS_SVH
`define RELAY_SEQ_CONSTS_SVH

`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 100000000
`define TB_WIDTH 22
`define FINE_WIDTH 10
`define MULT_WIDTH 16
`define LEN_WIDTH 26
`define FINE_RESET 10'h001
`define FINE_MIN 10'h001

`define REG_OP_FINE 8'h00
`define REG_BRK_FINE 8'h04
`define REG_STATUS 8'h08
`define REG_ELAPSED 8'h0C

`define MODE_SINGLE_OFF 3'h0
`define MODE_SINGLE_ON 3'h1
`define MODE_CYCLIC_OFF 3'h2
`define MODE_CYCLIC_ON 3'h3
`define MODE_STRAP 3'h4

`define RANGE_FORCED_OFF 3'h0
`define RANGE_FORCED_ON 3'h1
`define RANGE_TENTH 3'h2
`define RANGE_SEC 3'h3
`define RANGE_TEN_SEC 3'h4
`define RANGE_MIN 3'h5
`define RANGE_TEN_MIN 3'h6
`define RANGE_HOUR 3'h7

`define MULT_TENTH 16'h0001
`define MULT_SEC 16'h000A
`define MULT_TEN_SEC 16'h0064
`define MULT_MIN 16'h0258
`define MULT_TEN_MIN 16'h1770
`define MULT_HOUR 16'h8CA0

`endif

// file: rtl/relay_seq_pkg.sv
// Types shared by the relay sequencer
`include "relay_seq_consts.svh"
package relay_seq_pkg;
	typedef enum logic [4:0] {
		ST_INIT = 5'h01,
		ST_FIRST = 5'h02,
		ST_SECOND = 5'h04,
		ST_DONE_ON = 5'h08,
		ST_DONE_OFF = 5'h10
	} seq_state_t;

	typedef enum logic [2:0] {
		RUN_SINGLE_OFF = `MODE_SINGLE_OFF,
		RUN_SINGLE_ON = `MODE_SINGLE_ON,
		RUN_CYCLIC_OFF = `MODE_CYCLIC_OFF,
		RUN_CYCLIC_ON = `MODE_CYCLIC_ON
	} run_mode_t;
endpackage : relay_seq_pkg

// file: rtl/dual_interval_relay_sequencer.sv
// Dual-interval relay sequencer with APB register access
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "relay_seq_consts.svh"

// Summary of operation
// - Single off-delay: output released before power, energized for operating interval after.
// - Single off-delay: then released for break interval, then energized for good.
// - Single-run modes never repeat; only a new power-up restarts them.
// - Single on-delay: released for operating interval, energized for break, then released.
// - Cyclic off-delay: energized operating interval, released break interval, repeat forever.
// - Cyclic on-delay: released first interval, energized second, repeat forever.
// - Cyclic pair restarts straight after each break interval, no pause.
// - Strap fitted in two-function setting selects cyclic on-delay.
// - Forced-on range position holds output energized, ignoring the sequence.
// - Forced-off range position holds output released, ignoring the sequence.
// - Range and mode are sampled once after power-up and then frozen.
// - Fine time settings stay live and scale the active interval within latched range.
// - Two independent intervals, operating and break, from 0.1 s up to 1023 h.
module dual_interval_relay_sequencer
	import relay_seq_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] mode_knob,
	input wire logic [2:0] range_knob,
	input wire logic strap_fitted,
	output logic relay_out
);

	seq_state_t st_ff, nxt_st;
	run_mode_t mode_ff, nxt_mode;
	logic [2:0] range_ff, nxt_range;
	logic [`TB_WIDTH-1:0] tb_ff, nxt_tb;
	logic [`LEN_WIDTH-1:0] el_ff, nxt_el;
	logic relay_ff, nxt_relay;
	logic [`FINE_WIDTH-1:0] op_fine_ff, nxt_op_fine;
	logic [`FINE_WIDTH-1:0] brk_fine_ff, nxt_brk_fine;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;

	logic tick;
	logic phase_end;
	logic forced_on;
	logic forced_off;
	logic off_dly;
	logic cyclic;
	logic [`FINE_WIDTH-1:0] fine_sel;
	logic [`MULT_WIDTH-1:0] mult;
	logic [`LEN_WIDTH-1:0] len;
	logic [`LEN_WIDTH-1:0] el_inc;

	assign relay_out = relay_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Tick counter and phase length
	assign tick = (tb_ff == `TB_WIDTH'(TICK_CYCLES - 1));
	assign forced_on = (range_ff == `RANGE_FORCED_ON);
	assign forced_off = (range_ff == `RANGE_FORCED_OFF);
	assign off_dly = (mode_ff == RUN_SINGLE_OFF) || (mode_ff == RUN_CYCLIC_OFF);
	assign cyclic = (mode_ff == RUN_CYCLIC_OFF) || (mode_ff == RUN_CYCLIC_ON);
	assign el_inc = el_ff + `LEN_WIDTH'(1);

	always_comb begin
		fine_sel = (st_ff == ST_SECOND) ? brk_fine_ff : op_fine_ff;
		if (fine_sel < `FINE_MIN) begin
			fine_sel = `FINE_MIN;
		end
		case (range_ff)
			`RANGE_TENTH: mult = `MULT_TENTH;
			`RANGE_SEC: mult = `MULT_SEC;
			`RANGE_TEN_SEC: mult = `MULT_TEN_SEC;
			`RANGE_MIN: mult = `MULT_MIN;
			`RANGE_TEN_MIN: mult = `MULT_TEN_MIN;
			`RANGE_HOUR: mult = `MULT_HOUR;
			default: mult = `MULT_TENTH;
		endcase
		// Live fine setting; lowering it below elapsed time ends the phase at next tick
		len = `LEN_WIDTH'(fine_sel * mult);
		phase_end = tick && (el_inc >= len);
	end

	// Sequencer next state
	always_comb begin
		nxt_st = st_ff;
		nxt_mode = mode_ff;
		nxt_range = range_ff;
		nxt_tb = tick ? '0 : `TB_WIDTH'(tb_ff + `TB_WIDTH'(1));
		nxt_el = el_ff;
		if (tick) begin
			nxt_el = phase_end ? '0 : el_inc;
		end
		case (st_ff)
			ST_INIT: begin
				// Knobs and strap sampled once; later changes need a power cycle
				nxt_range = range_knob;
				case (mode_knob)
					`MODE_SINGLE_OFF: nxt_mode = RUN_SINGLE_OFF;
					`MODE_SINGLE_ON: nxt_mode = RUN_SINGLE_ON;
					`MODE_CYCLIC_OFF: nxt_mode = RUN_CYCLIC_OFF;
					`MODE_CYCLIC_ON: nxt_mode = RUN_CYCLIC_ON;
					`MODE_STRAP: nxt_mode = strap_fitted ? RUN_CYCLIC_ON : RUN_CYCLIC_OFF;
					default: nxt_mode = RUN_SINGLE_OFF;
				endcase
				nxt_tb = '0;
				nxt_el = '0;
				nxt_st = ST_FIRST;
			end
			ST_FIRST: begin
				if (phase_end) begin
					nxt_st = ST_SECOND;
				end
			end
			ST_SECOND: begin
				if (phase_end) begin
					if (cyclic) begin
						nxt_st = ST_FIRST;
					end else if (off_dly) begin
						nxt_st = ST_DONE_ON;
					end else begin
						nxt_st = ST_DONE_OFF;
					end
				end
			end
			ST_DONE_ON: nxt_st = ST_DONE_ON;
			ST_DONE_OFF: nxt_st = ST_DONE_OFF;
			default: nxt_st = ST_INIT;
		endcase
		// Output follows the state being entered so it never lags a phase edge
		if (nxt_range == `RANGE_FORCED_ON) begin
			nxt_relay = 1'b1;
		end else if (nxt_range == `RANGE_FORCED_OFF) begin
			nxt_relay = 1'b0;
		end else begin
			case (nxt_st)
				ST_FIRST: nxt_relay = (nxt_mode == RUN_SINGLE_OFF) ||
					(nxt_mode == RUN_CYCLIC_OFF);
				ST_SECOND: nxt_relay = !((nxt_mode == RUN_SINGLE_OFF) ||
					(nxt_mode == RUN_CYCLIC_OFF));
				ST_DONE_ON: nxt_relay = 1'b1;
				default: nxt_relay = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_INIT;
			mode_ff <= RUN_SINGLE_OFF;
			range_ff <= `RANGE_FORCED_OFF;
			tb_ff <= '0;
			el_ff <= '0;
			relay_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			mode_ff <= nxt_mode;
			range_ff <= nxt_range;
			tb_ff <= nxt_tb;
			el_ff <= nxt_el;
			relay_ff <= nxt_relay;
		end
	end

	// APB slave: one wait state, answer registered
	always_comb begin
		nxt_op_fine = op_fine_ff;
		nxt_brk_fine = brk_fine_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_pready = psel && penable && !pready_ff;
		if (nxt_pready) begin
			nxt_prdata = '0;
			case (paddr)
				`REG_OP_FINE: nxt_prdata = 32'(op_fine_ff);
				`REG_BRK_FINE: nxt_prdata = 32'(brk_fine_ff);
				`REG_STATUS: nxt_prdata = {19'h00000, range_ff, mode_ff, st_ff,
					forced_on || forced_off, relay_ff};
				`REG_ELAPSED: nxt_prdata = 32'(el_ff);
				default: nxt_pslverr = 1'b1;
			endcase
			if (pwrite && (paddr == `REG_STATUS || paddr == `REG_ELAPSED)) begin
				nxt_pslverr = 1'b1;
			end
		end
		// Writes land only at the completing edge
		if (psel && penable && pready_ff && pwrite) begin
			if (paddr == `REG_OP_FINE) begin
				nxt_op_fine = pwdata[`FINE_WIDTH-1:0];
			end
			if (paddr == `REG_BRK_FINE) begin
				nxt_brk_fine = pwdata[`FINE_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_fine_ff <= `FINE_RESET;
			brk_fine_ff <= `FINE_RESET;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			op_fine_ff <= nxt_op_fine;
			brk_fine_ff <= nxt_brk_fine;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_forced_on_hold: assert property ((st_ff != ST_INIT && forced_on) |-> relay_ff)
		else $error("forced-on position did not hold output energized");
	a_forced_off_hold: assert property ((st_ff != ST_INIT && forced_off) |-> !relay_ff)
		else $error("forced-off position did not hold output released");
	a_cfg_frozen: assert property ((st_ff != ST_INIT)
		|=> ($stable(mode_ff) && $stable(range_ff)))
		else $error("latched mode or range changed while powered");
	a_phase_level: assert property ((st_ff == ST_FIRST && !forced_on && !forced_off)
		|-> relay_ff == off_dly)
		else $error("first phase output level wrong for mode");
	a_second_level: assert property ((st_ff == ST_SECOND && !forced_on && !forced_off)
		|-> relay_ff != off_dly)
		else $error("second phase output level wrong for mode");
	a_single_finish: assert property ((!cyclic && st_ff == ST_SECOND && phase_end)
		|=> (st_ff == (off_dly ? ST_DONE_ON : ST_DONE_OFF)))
		else $error("single run did not settle in its final state");
	a_no_rerun: assert property ((st_ff == ST_DONE_ON || st_ff == ST_DONE_OFF)
		|=> $stable(st_ff) [*4])
		else $error("single run sequence restarted");
	a_cyclic_restart: assert property ((cyclic && st_ff == ST_SECOND && phase_end)
		|=> (st_ff == ST_FIRST && el_ff == '0))
		else $error("cyclic pair did not restart at once");
	a_strap_on: assert property ((st_ff == ST_INIT && strap_fitted
		&& mode_knob == `MODE_STRAP) |=> mode_ff == RUN_CYCLIC_ON)
		else $error("fitted strap did not select cyclic on-delay");
	a_strap_off: assert property ((st_ff == ST_INIT && !strap_fitted
		&& mode_knob == `MODE_STRAP) |=> mode_ff == RUN_CYCLIC_OFF)
		else $error("missing strap did not select cyclic off-delay");
	a_phase_hold: assert property ((st_ff == ST_FIRST && !phase_end) |=> st_ff == ST_FIRST)
		else $error("phase left before its interval elapsed");
	a_init_start: assert property ((st_ff == ST_INIT) |=> (st_ff == ST_FIRST && tb_ff == '0))
		else $error("sequence did not start at first phase");

endmodule : dual_interval_relay_sequencer

// file: tb/relay_load_model.sv
// Relay coil driver and switched load seen from the sequencer output
`timescale 1ns/1ps
module relay_load_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic coil,
	output logic contact,
	output int switch_count
);
	// Unpowered load sits released; count resets with power
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			contact <= 1'b0;
			switch_count <= 0;
		end else begin
			contact <= coil;
			if (coil !== contact) begin
				switch_count <= switch_count + 1;
			end
		end
	end
endmodule : relay_load_model

// file: tb/dual_interval_relay_sequencer_bench.sv
// Self-checking bench for the dual-interval relay sequencer
`timescale 1ns/1ps
`include "relay_seq_consts.svh"
module dual_interval_relay_sequencer_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap_fitted = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] mode_knob = 3'h0, range_knob = 3'h0;
	logic pready, pslverr, relay_out, contact, er, chk = 0;
	int num_errors = 0, num_checks = 0, k = 0, cyc = 0, l1 = 4, l2 = 4, em = 0, rr = 2, sw, swn;
	always #20 pclk = ~pclk;
	dual_interval_relay_sequencer #(.TICK_CYCLES(4)) i_dual_interval_relay_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_knob(mode_knob),
		.range_knob(range_knob), .strap_fitted(strap_fitted), .relay_out(relay_out));
	relay_load_model i_relay_load_model (.clk(pclk), .rst_n(presetn), .coil(relay_out),
		.contact(contact), .switch_count(sw));
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk_val
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Phase position; cyclic modes wrap on the pair length
	function automatic int pos(input int kk);
		return (em >= 2) ? (kk - 1) % (l1 + l2) : kk - 1;
	endfunction : pos
	function automatic logic exp_level(input int kk);
		logic first;
		first = (em == 0 || em == 2);
		if (rr < 2) return rr == 1;
		if (pos(kk) < l1) return first;
		if (pos(kk) < l1 + l2) return !first;
		return em == 0;
	endfunction : exp_level
	// Edge placement at phase ends is the designer's; skip one cycle either side
	function automatic bit near(input int kk);
		int d;
		d = pos(kk);
		return d <= 1 || (d >= l1 - 1 && d <= l1 + 1) || (d >= l1 + l2 - 1 && d <= l1 + l2 + 1);
	endfunction : near
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		k <= presetn ? k + 1 : 0;
		if (chk && k > 2 && (rr < 2 || !near(k))) begin
			chk_val("relay_out", exp_level(k), relay_out);
		end
		// Snapshot after two full pairs; bus traffic may still be running then
		if (k == 2 * (l1 + l2) + 3) begin
			swn <= sw;
		end
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic run(input int m, input int r, input logic s);
		int f1, f2, mult;
		chk = 0;
		presetn <= 1'b0;
		mode_knob <= 3'(m);
		range_knob <= 3'(r);
		strap_fitted <= s;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		em = (m == 4) ? (s ? 3 : 2) : (m > 4 ? 0 : m);
		rr = r;
		mult = (r == 3) ? 40 : 4;
		f1 = (r == 3) ? 1 + $urandom % 3 : 1;
		f2 = (r == 3) ? 1 + $urandom % 3 : 1;
		l1 = f1 * mult;
		l2 = f2 * mult;
		chk = 1;
		apb(1'b1, `REG_OP_FINE, 32'(f1));
		chk_val("wr_err", 32'h0, 32'(er));
		apb(1'b1, `REG_BRK_FINE, 32'(f2));
		apb(1'b0, `REG_OP_FINE, 32'h0);
		chk_val("op_fine", 32'(f1), rd);
		apb(1'b0, `REG_BRK_FINE, 32'h0);
		chk_val("brk_fine", 32'(f2), rd);
		apb(1'b1, `REG_STATUS, 32'hFFFFFFFF);
		chk_val("ro_write_err", 32'h1, 32'(er));
		apb(1'b0, 8'h10, 32'h0);
		chk_val("unmapped_err", 32'h1, 32'(er));
		// Knob moves while powered must not matter
		mode_knob <= 3'($urandom);
		range_knob <= 3'($urandom);
		strap_fitted <= ~s;
		while (k <= 2 * (l1 + l2) + 3) @(posedge pclk);
		chk_val("switches", (rr < 2) ? rr : (em == 0 || em == 2) + ((em >= 2) ? 4 : 2), swn);
	endtask : run
	initial begin
		void'($urandom(19));
		for (int i = 0; i < 6; i++) begin
			run(i == 5 ? 4 : i, 3, i == 5);
		end
		run(2, 2, 1'b0);
		run(3, 0, 1'b0);
		run(1, 1, 1'b0);
		run(7, 3, 1'b0);
		stop_test();
	end
endmodule : dual_interval_relay_sequencer_bench
